//--- hw/tt_timer.sv
// Purpose: 8-bit tick timer with clock source select and timeout interrupt
// Assumes: Avalon-MM slave with byte addresses, data in the low byte
// Notes: every access answers in two cycles; unmapped reads return zero
`timescale 1ns/10ps
module tt_timer import tt_pkg::*; #(
    parameter int SYS_DIV = SYS_DIV_DEF
) (
    input wire logic CLOCK_I,                 // 50 MHz system clock
    input wire logic RESET_I,                 // synchronous reset, active high
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,  // byte address
    input wire logic AVS_READ_I,              // read request
    input wire logic AVS_WRITE_I,             // write request
    input wire logic [3:0] AVS_BYTEENABLE_I,  // byte lanes
    input wire logic [31:0] AVS_WRITEDATA_I,  // write data
    output logic [31:0] AVS_READDATA_O,       // read data, registered
    output logic AVS_WAITREQUEST_O,           // stall until answer
    input wire logic EXT_CLK_I,               // external crystal clock
    output logic IRQ_O,                       // level interrupt
    output logic [7:0] IRQ_VECTOR_O,          // service routine address
    output logic TICK_CLK_EN_O                // timer input clock enable, shared
);
    logic ack_ff;
    logic req;
    logic wr_acc;
    logic [7:0] wbyte;
    logic [7:0] flags_ff;
    logic [7:0] enables_ff;
    logic [7:0] count_ff;
    logic clear_n_ff;
    logic run_ff;
    logic [CTL_SEL_W-1:0] sel_ff;
    logic [7:0] clksel_ff;
    logic [7:0] rd_mux;
    logic [7:0] ctl_view;
    logic tick_en;
    logic cnt_tick;
    logic cnt_step;
    logic [7:0] count_nxt;
    logic tm_evt;
    logic [7:0] vector_ff;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
        hit = (a == reg_addr(idx));
    endfunction : hit

    // bus handshake: one wait cycle, write lands and read data stand at the release edge
    assign req = AVS_READ_I | AVS_WRITE_I;
    assign AVS_WAITREQUEST_O = req & ~ack_ff;
    assign wr_acc = AVS_WRITE_I & ack_ff & AVS_BYTEENABLE_I[0];
    assign wbyte = AVS_WRITEDATA_I[7:0];

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    assign ctl_view = {clear_n_ff, 3'b000, run_ff, sel_ff};

    always_comb begin
        rd_mux = 8'h00;
        if (hit(AVS_ADDRESS_I, IDX_FLAGS)) begin
            rd_mux = flags_ff;
        end else if (hit(AVS_ADDRESS_I, IDX_ENABLES)) begin
            rd_mux = enables_ff;
        end else if (hit(AVS_ADDRESS_I, IDX_COUNT)) begin
            rd_mux = count_ff;
        end else if (hit(AVS_ADDRESS_I, IDX_CTL)) begin
            rd_mux = ctl_view;
        end else if (hit(AVS_ADDRESS_I, IDX_CLKSEL)) begin
            rd_mux = clksel_ff;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            AVS_READDATA_O <= RDATA_ZERO;
        end else if (AVS_READ_I & ~ack_ff) begin
            AVS_READDATA_O <= {24'h00_0000, rd_mux};
        end
    end

    // clock source selection
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            clksel_ff <= RST_CLKSEL;
        end else if (wr_acc && hit(AVS_ADDRESS_I, IDX_CLKSEL)) begin
            clksel_ff <= wbyte & CLKSEL_MASK;
        end
    end

    tt_clk_tree #(.SYS_DIV(SYS_DIV)) u_clk (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .ext_clk_i(EXT_CLK_I),
        .main_sel_i(clksel_ff[CK_MAIN_BIT]),
        .ext_half_i(clksel_ff[CK_HALVE_BIT]),
        .sys_div_i(clksel_ff[CK_SYSDIV_BIT]),
        .tick_src_i(clksel_ff[CK_TICKSRC_BIT]),
        .tick_en_o(tick_en)
    );
    assign TICK_CLK_EN_O = tick_en;

    tt_pulse_div #(.DIV(PRESCALE_DIV)) u_pre (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .en_i(tick_en),
        .pulse_o(cnt_tick)
    );

    // control register; clear bit restores itself the cycle after it acts
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            clear_n_ff <= RST_CTL[CTL_CLEAR_N_BIT];
            run_ff <= RST_CTL[CTL_RUN_BIT];
            sel_ff <= RST_CTL[CTL_SEL_LSB +: CTL_SEL_W];
        end else if (wr_acc && hit(AVS_ADDRESS_I, IDX_CTL)) begin
            clear_n_ff <= wbyte[CTL_CLEAR_N_BIT];
            run_ff <= wbyte[CTL_RUN_BIT];
            sel_ff <= wbyte[CTL_SEL_LSB +: CTL_SEL_W];
        end else begin
            clear_n_ff <= 1'b1;
        end
    end

    // counter; clear beats a step landing in the same cycle
    assign cnt_step = cnt_tick & run_ff & clear_n_ff;
    assign count_nxt = count_ff + COUNT_STEP;

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            count_ff <= RST_COUNT;
        end else if (!clear_n_ff) begin
            count_ff <= RST_COUNT;
        end else if (cnt_step) begin
            count_ff <= count_nxt;
        end
    end

    // timeout only on a real step, so a clear never fakes a falling edge
    assign tm_evt = cnt_step & count_ff[sel_ff] & ~count_nxt[sel_ff];

    // sticky flag: a new timeout wins over a write-one-to-clear in the same cycle
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            flags_ff <= RST_FLAGS;
        end else begin
            flags_ff[FLAG_TIMER_BIT] <= tm_evt | (flags_ff[FLAG_TIMER_BIT]
                & ~(wr_acc && hit(AVS_ADDRESS_I, IDX_FLAGS) && wbyte[FLAG_TIMER_BIT]));
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            enables_ff <= RST_ENABLES;
        end else if (wr_acc && hit(AVS_ADDRESS_I, IDX_ENABLES)) begin
            enables_ff <= wbyte & ENABLES_MASK;
        end
    end

    assign IRQ_O = enables_ff[EN_GLOBAL_BIT] & |(flags_ff & enables_ff & FLAGS_MASK);

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            vector_ff <= IRQ_VECTOR;
        end else begin
            vector_ff <= IRQ_VECTOR;
        end
    end
    assign IRQ_VECTOR_O = vector_ff;

    // checks
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RESET_I);

    property p_prescale;
        cnt_tick |=> !cnt_tick [*3];
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler pulses closer than four");

    property p_step;
        cnt_step |=> count_ff == $past(count_nxt);
    endproperty
    a_step: assert property (p_step) else $error("counter did not step by one");

    property p_sel_edge;
        tm_evt |=> count_ff[$past(sel_ff)] == 1'b0 && $past(count_ff[sel_ff]) == 1'b1;
    endproperty
    a_sel_edge: assert property (p_sel_edge) else $error("timeout without falling edge");

    property p_evt_flag;
        tm_evt |=> flags_ff[FLAG_TIMER_BIT] ##1 flags_ff[FLAG_TIMER_BIT] || $past(wr_acc);
    endproperty
    a_evt_flag: assert property (p_evt_flag) else $error("timeout did not set the flag");

    property p_flag_hold;
        flags_ff[FLAG_TIMER_BIT] && !(wr_acc && hit(AVS_ADDRESS_I, IDX_FLAGS))
            |=> flags_ff[FLAG_TIMER_BIT];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

    property p_irq;
        IRQ_O == (flags_ff[FLAG_TIMER_BIT] && enables_ff[EN_TIMER_BIT]
            && enables_ff[EN_GLOBAL_BIT]);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output mismatch");

    property p_clear;
        !clear_n_ff |=> count_ff == RST_COUNT && clear_n_ff;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero and restore");

    property p_stop;
        !run_ff && clear_n_ff && $stable(run_ff) |=> $stable(count_ff);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    property p_answer;
        req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");

    property p_vector;
        IRQ_VECTOR_O == IRQ_VECTOR;
    endproperty
    a_vector: assert property (p_vector) else $error("vector output wrong");

    property p_rdata_hi;
        AVS_READDATA_O[31:8] == 24'h00_0000;
    endproperty
    a_rdata_hi: assert property (p_rdata_hi) else $error("upper read data not zero");

    property p_set_wins;
        tm_evt |=> flags_ff[FLAG_TIMER_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("timeout lost to a clear");

    property p_w1c;
        !tm_evt && wr_acc && hit(AVS_ADDRESS_I, IDX_FLAGS) && wbyte[FLAG_TIMER_BIT]
            |=> !flags_ff[FLAG_TIMER_BIT];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

    property p_no_evt_stop;
        !run_ff |-> !tm_evt;
    endproperty
    a_no_evt_stop: assert property (p_no_evt_stop) else $error("timeout while stopped");

    property p_clear_bit;
        wr_acc && hit(AVS_ADDRESS_I, IDX_CTL) && !wbyte[CTL_CLEAR_N_BIT] |=> !clear_n_ff;
    endproperty
    a_clear_bit: assert property (p_clear_bit) else $error("clear write not taken");

    property p_count_hold;
        !cnt_step && clear_n_ff |=> $stable(count_ff);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved without step");

    property p_irq_gate;
        !enables_ff[EN_GLOBAL_BIT] || !enables_ff[EN_TIMER_BIT] |-> !IRQ_O;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

    c_evt: cover property (tm_evt);
    c_irq: cover property (!IRQ_O ##1 IRQ_O);
    c_clear: cover property (!clear_n_ff ##1 clear_n_ff);
    c_wrap: cover property (cnt_step && count_ff == 8'hff);
    c_stop: cover property (!run_ff && cnt_tick);
endmodule : tt_timer

//--- hw/tt_pkg.sv
// Purpose: shared constants for the tick timer with clock select
// Assumes: 50 MHz system clock, registers reached over Avalon-MM
// Notes: register indices are kept as printed, byte address is four times the index
package tt_pkg;
    // clock rates and divide ratios
    localparam int CLK_HZ = 50_000_000;
    localparam int ICK_HZ = 1_000_000;
    localparam int ICK_DIV = CLK_HZ / ICK_HZ;
    localparam int ECK_HZ = 32_768;
    localparam int EXT_HALVE_DIV = 2;
    localparam int SYS_DIV_DEF = 4;
    localparam int TICK_SYS_DIV = 1000;
    localparam int TICK_EXT_DIV = 32;
    localparam int PRESCALE_DIV = 4;
    // 1024 Hz timer input gives 1/128 s at bit 0 up to 1 s at bit 7
    localparam int TICK_REF_HZ = ECK_HZ / TICK_EXT_DIV;

    // register indices and bus geometry
    localparam int ADDR_W = 8;
    localparam logic [5:0] IDX_FLAGS = 6'h06;
    localparam logic [5:0] IDX_ENABLES = 6'h07;
    localparam logic [5:0] IDX_COUNT = 6'h0e;
    localparam logic [5:0] IDX_CTL = 6'h0f;
    localparam logic [5:0] IDX_CLKSEL = 6'h14;

    // field positions
    localparam int FLAG_TIMER_BIT = 4;
    localparam int EN_TIMER_BIT = 4;
    localparam int EN_GLOBAL_BIT = 7;
    localparam int CTL_CLEAR_N_BIT = 7;
    localparam int CTL_RUN_BIT = 3;
    localparam int CTL_SEL_LSB = 0;
    localparam int CTL_SEL_W = 3;
    localparam int CK_MAIN_BIT = 0;
    localparam int CK_SYSDIV_BIT = 1;
    localparam int CK_HALVE_BIT = 3;
    localparam int CK_TICKSRC_BIT = 5;

    // implemented-bit masks and reset values
    localparam logic [7:0] FLAGS_MASK = 8'h10;
    localparam logic [7:0] ENABLES_MASK = 8'h90;
    localparam logic [7:0] CTL_MASK = 8'h8f;
    localparam logic [7:0] CLKSEL_MASK = 8'h2b;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_CTL = 8'h80;
    localparam logic [7:0] RST_CLKSEL = 8'h00;
    localparam logic [7:0] COUNT_STEP = 8'h01;
    localparam logic [7:0] IRQ_VECTOR = 8'h04;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [5:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction : reg_addr
endpackage : tt_pkg

//--- hw/tt_pulse_div.sv
// Purpose: divides a stream of one-cycle enable pulses by a fixed ratio
// Assumes: en_i is a one-cycle enable in the system clock domain
// Notes: output pulse coincides with the DIV-th input pulse
`timescale 1ns/10ps
module tt_pulse_div #(
    parameter int DIV = 2
) (
    input wire logic clk_i,  // system clock
    input wire logic rst_i,  // synchronous reset, active high
    input wire logic en_i,   // input enable pulse
    output logic pulse_o     // divided enable pulse
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    localparam logic [W-1:0] ONE = W'(1);

    logic [W-1:0] cnt_ff;

    assign pulse_o = en_i && (cnt_ff == LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else if (en_i) begin
            cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + ONE;
        end
    end
endmodule : tt_pulse_div

//--- hw/tt_clk_tree.sv
// Purpose: builds the timer input clock enable from internal and external sources
// Assumes: the crystal clock pin is sampled as a synchronous input
// Notes: every derived rate is a one-cycle enable, never a real clock
`timescale 1ns/10ps
module tt_clk_tree import tt_pkg::*; #(
    parameter int SYS_DIV = SYS_DIV_DEF
) (
    input wire logic clk_i,        // system clock
    input wire logic rst_i,        // synchronous reset, active high
    input wire logic ext_clk_i,    // external crystal clock level
    input wire logic main_sel_i,   // master clock from external source
    input wire logic ext_half_i,   // halve the external source for the master clock
    input wire logic sys_div_i,    // divide master clock for system clock
    input wire logic tick_src_i,   // timer input from external /32
    output logic tick_en_o         // timer input clock enable
);
    logic eck_d_ff;
    logic ick_en;
    logic eck_en;
    logic eck_half_en;
    logic mck_en;
    logic sys_p;
    logic clk_en;
    logic tick_sys_p;
    logic tick_ext_p;

    // internal oscillator derived from the system clock
    tt_pulse_div #(.DIV(ICK_DIV)) u_ick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(1'b1),
        .pulse_o(ick_en)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eck_d_ff <= 1'b0;
        end else begin
            eck_d_ff <= ext_clk_i;
        end
    end
    assign eck_en = ext_clk_i & ~eck_d_ff;

    tt_pulse_div #(.DIV(EXT_HALVE_DIV)) u_half (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(eck_en),
        .pulse_o(eck_half_en)
    );
    assign mck_en = main_sel_i ? (ext_half_i ? eck_half_en : eck_en) : ick_en;

    tt_pulse_div #(.DIV(SYS_DIV)) u_sys (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(mck_en),
        .pulse_o(sys_p)
    );
    assign clk_en = sys_div_i ? sys_p : mck_en;

    tt_pulse_div #(.DIV(TICK_SYS_DIV)) u_tsys (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(clk_en),
        .pulse_o(tick_sys_p)
    );
    tt_pulse_div #(.DIV(TICK_EXT_DIV)) u_text (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(eck_en),
        .pulse_o(tick_ext_p)
    );
    // ratios stay running across a source change, so the first period after it may be short
    assign tick_en_o = tick_src_i ? tick_ext_p : tick_sys_p;
endmodule : tt_clk_tree

//--- sim/tb_tick_timer_with_clock_select.sv
// Purpose: self-checking bench for the tick timer with clock select
// Assumes: EXT_CLK_I toggles every clock, so the external path is the fast one
// Notes: long timeouts (select 6 and 7) are only read back, the run would be too long
`timescale 1ns/10ps
module tb_tick_timer_with_clock_select import tt_pkg::*;;
    localparam int LIMIT = 90000;
    logic CLOCK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic [ADDR_W-1:0] AVS_ADDRESS_I = '0;
    logic AVS_READ_I = 1'b0;
    logic AVS_WRITE_I = 1'b0;
    logic [3:0] AVS_BYTEENABLE_I = 4'hf;
    logic [31:0] AVS_WRITEDATA_I = '0;
    logic [31:0] AVS_READDATA_O;
    logic AVS_WAITREQUEST_O;
    logic EXT_CLK_I = 1'b0;
    logic IRQ_O;
    logic [7:0] IRQ_VECTOR_O;
    logic TICK_CLK_EN_O;
    int mismatches = 0;
    int checks = 0;
    int seed = 12710;
    int cyc = 0;
    int ticks = 0;
    int last_tick = 0;
    bit gap_on = 1'b0;
    int gap_exp = 64;
    logic [8:0] notes[$];
    logic [8:0] note;
    logic [31:0] rv;
    logic [31:0] rnd;

    tt_timer #(.SYS_DIV(2)) u_dut (
        .CLOCK_I(CLOCK_I),
        .RESET_I(RESET_I),
        .AVS_ADDRESS_I(AVS_ADDRESS_I),
        .AVS_READ_I(AVS_READ_I),
        .AVS_WRITE_I(AVS_WRITE_I),
        .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
        .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
        .AVS_READDATA_O(AVS_READDATA_O),
        .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
        .EXT_CLK_I(EXT_CLK_I),
        .IRQ_O(IRQ_O),
        .IRQ_VECTOR_O(IRQ_VECTOR_O),
        .TICK_CLK_EN_O(TICK_CLK_EN_O)
    );

    initial begin
        forever #10 CLOCK_I = ~CLOCK_I;
    end

    always @(posedge CLOCK_I) begin
        EXT_CLK_I <= ~EXT_CLK_I;
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            mismatches++;
            $display("BAD t=%0t timeout", $time);
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one request held until waitrequest is seen low, released at that same edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge CLOCK_I);
        rnd = $random(seed);
        AVS_ADDRESS_I <= {idx, 2'b00};
        AVS_WRITEDATA_I <= {rnd[23:0], d};
        AVS_WRITE_I <= wr;
        AVS_READ_I <= !wr;
        do begin
            @(posedge CLOCK_I);
            n++;
        end while (AVS_WAITREQUEST_O !== 1'b0 && n < 20);
        if (n >= 20) begin
            mismatches++;
            $display("BAD t=%0t bus hang", $time);
        end
        rv = AVS_READDATA_O;
        AVS_WRITE_I <= 1'b0;
        AVS_READ_I <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input bit cmp, input logic [7:0] exp);
        notes.push_back({cmp, exp});
        bus(1'b0, idx, 8'h00);
    endtask : rd

    // read results are judged here, in the cycle where the answer stands
    always @(negedge CLOCK_I) begin
        if (AVS_READ_I === 1'b1 && AVS_WAITREQUEST_O === 1'b0 && notes.size() > 0) begin
            note = notes.pop_front();
            if (note[8]) chk(AVS_READDATA_O, {24'h00_0000, note[7:0]});
        end
        if (TICK_CLK_EN_O === 1'b1) begin
            if (gap_on) chk(32'(cyc - last_tick), 32'(gap_exp));
            last_tick = cyc;
            ticks++;
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    initial begin
        int k;
        int j;
        logic [7:0] d;
        logic [7:0] c1;
        repeat (2) @(posedge CLOCK_I);
        RESET_I <= 1'b0;
        rd(IDX_FLAGS, 1'b1, RST_FLAGS);
        rd(IDX_ENABLES, 1'b1, RST_ENABLES);
        rd(IDX_COUNT, 1'b1, RST_COUNT);
        rd(IDX_CTL, 1'b1, RST_CTL);
        rd(IDX_CLKSEL, 1'b1, RST_CLKSEL);
        chk(32'(IRQ_O), 32'h0000_0000);
        chk(32'(IRQ_VECTOR_O), 32'h0000_0004);
        $display("test reset done");
        for (k = 0; k < 4; k++) begin
            d = 8'($random(seed));
            wr(IDX_ENABLES, d);
            rd(IDX_ENABLES, 1'b1, d & ENABLES_MASK);
            wr(IDX_CLKSEL, d);
            rd(IDX_CLKSEL, 1'b1, d & CLKSEL_MASK);
            wr(IDX_CTL, d | 8'h80);
            rd(IDX_CTL, 1'b1, (d | 8'h80) & CTL_MASK);
        end
        // lane 0 off: the write must not land
        AVS_BYTEENABLE_I <= 4'he;
        wr(IDX_ENABLES, 8'h90);
        AVS_BYTEENABLE_I <= 4'hf;
        rd(IDX_ENABLES, 1'b1, d & ENABLES_MASK);
        wr(6'h10, 8'hff);
        rd(6'h10, 1'b1, 8'h00);
        $display("test registers done");
        wr(IDX_ENABLES, 8'h00);
        wr(IDX_CLKSEL, 8'h20);
        // dividers are not reset on a source change, so let the first odd gap pass
        repeat (200) @(posedge CLOCK_I);
        gap_on = 1'b1;
        for (k = 0; k < 6; k++) begin
            wr(IDX_CTL, 8'h08 | 8'(k));
            ticks = 0;
            wr(IDX_FLAGS, 8'h10);
            rd(IDX_FLAGS, 1'b1, 8'h00);
            j = 0;
            do begin
                rd(IDX_FLAGS, 1'b0, 8'h00);
                j++;
            end while (rv[4] !== 1'b1 && j < 20000);
            rd(IDX_COUNT, 1'b1, 8'h01 << (k + 1));
            chk(32'(ticks >= 8 * (1 << k) - 4 && ticks <= 8 * (1 << k) + 1), 32'h0000_0001);
            $display("test select %0d done", k);
        end
        rd(IDX_FLAGS, 1'b1, 8'h10);
        for (k = 0; k < 4; k++) begin
            wr(IDX_ENABLES, {k[1], 2'b00, k[0], 4'h0});
            @(negedge CLOCK_I);
            chk(32'(IRQ_O), 32'(k == 3));
        end
        wr(IDX_FLAGS, 8'h10);
        @(negedge CLOCK_I);
        chk(32'(IRQ_O), 32'h0000_0000);
        $display("test interrupt done");
        wr(IDX_CTL, 8'h80);
        rd(IDX_COUNT, 1'b0, 8'h00);
        c1 = rv[7:0];
        repeat (600) @(posedge CLOCK_I);
        rd(IDX_COUNT, 1'b1, c1);
        wr(IDX_CTL, 8'h00);
        rd(IDX_COUNT, 1'b1, 8'h00);
        rd(IDX_CTL, 1'b1, 8'h80);
        $display("test stop and clear done");
        // halved external master clock, then the divided system clock, both through /1000
        gap_on = 1'b0;
        wr(IDX_CLKSEL, 8'h09);
        repeat (4200) @(posedge CLOCK_I);
        gap_exp = 4000;
        gap_on = 1'b1;
        repeat (8100) @(posedge CLOCK_I);
        gap_on = 1'b0;
        wr(IDX_CLKSEL, 8'h0b);
        repeat (8200) @(posedge CLOCK_I);
        gap_exp = 8000;
        gap_on = 1'b1;
        repeat (16100) @(posedge CLOCK_I);
        gap_on = 1'b0;
        $display("test clock select done");
        summarize();
    end
endmodule : tb_tick_timer_with_clock_select
